// File: include/p1lc_consts.svh
// Offsets, field positions, reset values and timing counts of the port 1 link control
//
// Function
// - Bit 22 makes the reference clock pin an input when 0 and drives it out when 1.
// - Bit 21 picks 16 mA over 12 mA clock drive in RMII and 200 Mbps MII PHY, else 12 mA.
// - Bit 16 set turns the heartbeat test off, clear turns it on, only in MII PHY mode.
// - Loopback bit 14 in PHY modes returns external MAC frames and keeps them off the switch.
// - Speed bit 13 picks 10 Mbps when 0 and the higher rate when 1 in PHY modes.
// - Isolate bit 10 in PHY modes stops link outputs, drops pulls and ignores link inputs.
// - Duplex bit 8 gives full when 1; used in PHY modes, in MAC mode only with manual duplex.
// - Collision test bit 7 in MII PHY mode shows collision while the external MAC transmits.
// - Clock direction, drive level, heartbeat disable and speed load from straps at reset.
// - Duplex resets to 1 when the polarity strap equals the duplex pin, else to 0.
// - Turbo bit 26 makes the higher speed 200 Mbps when set and 100 Mbps when clear.
// - Read-only bits 25:24 report 00 MII MAC, 01 MII PHY, 10 RMII PHY, 11 internal PHY.
// - In MII MAC mode with manual duplex bit 28 clear, duplex follows pin and polarity strap.
`ifndef P1LC_CONSTS_SVH
`define P1LC_CONSTS_SVH

`define P1LC_ADDR_W       12
`define P1LC_CTRL_OFS     12'h1EC
`define P1LC_BIT_MANDUP   28
`define P1LC_BIT_TURBO    26
`define P1LC_BIT_MODE_HI  25
`define P1LC_BIT_MODE_LO  24
`define P1LC_BIT_CKDIR    22
`define P1LC_BIT_CKSTR    21
`define P1LC_BIT_HBDIS    16
`define P1LC_BIT_LOOP     14
`define P1LC_BIT_SPEED    13
`define P1LC_BIT_ISO      10
`define P1LC_BIT_DUPLEX   8
`define P1LC_BIT_COLT     7
`define P1LC_RW_MASK      32'h1461_6580
`define P1LC_RD_MASK      32'h1761_6580
`define P1LC_CTRL_RST     32'h0000_0000
`define P1LC_STRAP_WAIT   2'h2
`define P1LC_HB_CYCLES    4'h4
`define P1LC_NSYNC        8

`endif

// File: include/p1lc_pkg.sv
// Types shared by the port 1 link control block
package p1lc_pkg;

  typedef enum logic [1:0] {
    P1LC_MII_MAC,
    P1LC_MII_PHY,
    P1LC_RMII_PHY,
    P1LC_INT_PHY
  } p1lc_mode_type;

  typedef enum logic [1:0] {
    P1LC_SPD_10,
    P1LC_SPD_100,
    P1LC_SPD_200
  } p1lc_speed_type;

endpackage : p1lc_pkg

// File: include/p1lc_ctl_if.sv
// Control levels from the register domain to the link domain
`timescale 1ns/1ps
interface p1lc_ctl_if;
  logic ce;
  logic loop_en;
  logic iso_en;
  logic colt_en;
  logic hb_en;
  logic full_dup;
  logic phy_mode;
  logic mii_phy;

  modport ctl  (output ce, loop_en, iso_en, colt_en, hb_en, full_dup, phy_mode, mii_phy);
  modport link (input  ce, loop_en, iso_en, colt_en, hb_en, full_dup, phy_mode, mii_phy);
endinterface : p1lc_ctl_if

// File: design/p1lc_link.sv
// Link-clock side of port 1: loopback, isolate, collision test and heartbeat
`timescale 1ns/1ps
`include "p1lc_consts.svh"
module p1lc_link (
  input  logic       link_clk,
  input  logic       rst_b,
  p1lc_ctl_if.link   ctl,
  input  logic       mii_tx_en,
  input  logic [3:0] mii_txd,
  output logic       mii_rx_dv,
  output logic [3:0] mii_rxd,
  output logic       mii_crs,
  output logic       mii_col,
  output logic       mii_out_oe,
  output logic       link_pull_en,
  input  logic       sw_tx_en,
  input  logic [3:0] sw_txd,
  output logic       sw_rx_dv,
  output logic [3:0] sw_rxd
);

  logic [`P1LC_NSYNC-1:0] s1_r;
  logic [`P1LC_NSYNC-1:0] s2_r;
  logic                   ce_q;
  logic                   loop_q;
  logic                   iso_q;
  logic                   colt_q;
  logic                   hb_q;
  logic                   full_q;
  logic                   tx_act;
  logic                   tx_prev_r;
  logic [3:0]             hb_cnt_r;

  // Two-stage level crossing
  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_r <= '0;
      s2_r <= '0;
    end else begin
      s1_r <= {ctl.ce, ctl.loop_en, ctl.iso_en, ctl.colt_en,
               ctl.hb_en, ctl.full_dup, ctl.phy_mode, ctl.mii_phy};
      s2_r <= s1_r;
    end
  end

  assign ce_q   = s2_r[7];
  assign loop_q = s2_r[6];
  assign iso_q  = s2_r[5];
  assign colt_q = s2_r[4];
  assign hb_q   = s2_r[3];
  assign full_q = s2_r[2];

  assign tx_act = mii_tx_en & ~iso_q;

  assign mii_out_oe   = ~iso_q;
  assign link_pull_en = ~iso_q;

  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_prev_r <= 1'b0;
      hb_cnt_r  <= 4'h0;
    end else if (ce_q) begin
      tx_prev_r <= tx_act;
      if (hb_q && tx_prev_r && !tx_act)
        hb_cnt_r <= `P1LC_HB_CYCLES;
      else if (hb_cnt_r != 4'h0)
        hb_cnt_r <= hb_cnt_r - 4'h1;
    end
  end

  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      mii_rx_dv <= 1'b0;
      mii_rxd   <= 4'h0;
      sw_rx_dv  <= 1'b0;
      sw_rxd    <= 4'h0;
    end else if (ce_q) begin
      mii_rx_dv <= loop_q ? tx_act : sw_tx_en;
      mii_rxd   <= loop_q ? mii_txd : sw_txd;
      sw_rx_dv  <= tx_act & ~loop_q;
      sw_rxd    <= loop_q ? 4'h0 : mii_txd;
    end
  end

  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      mii_col <= 1'b0;
      mii_crs <= 1'b0;
    end else if (ce_q) begin
      mii_col <= (colt_q & tx_act) | (hb_cnt_r != 4'h0) |
                 (~full_q & ~loop_q & tx_act & sw_tx_en);
      mii_crs <= (~full_q & tx_act) | (loop_q ? tx_act : sw_tx_en);
    end
  end

  a_loop_return: assert property (
    @(posedge link_clk) disable iff (!rst_b)
    (ce_q && loop_q && $stable(s2_r)) |=> (mii_rx_dv == $past(tx_act)) && !sw_rx_dv)
    else $error("loopback frame not returned or leaked to switch");

  a_iso_quiet: assert property (
    @(posedge link_clk) disable iff (!rst_b)
    iso_q |-> (!mii_out_oe && !link_pull_en && !tx_act))
    else $error("isolated link still driven");

  a_iso_ignore: assert property (
    @(posedge link_clk) disable iff (!rst_b)
    (ce_q && iso_q) |=> !sw_rx_dv)
    else $error("isolated link input reached the switch");

  a_col_test: assert property (
    @(posedge link_clk) disable iff (!rst_b)
    (ce_q && colt_q && tx_act && $stable(s2_r)) |=> mii_col)
    else $error("collision test not shown during transmit");

endmodule : p1lc_link

// File: design/p1lc_top.sv
// Port 1 link basic control register with APB access and link-side control
//
// Design decisions made here: the APB register port and the address map.
`timescale 1ns/1ps
`include "p1lc_consts.svh"
module p1lc_top (
  input  logic                    clk,
  input  logic                    rst_b,
  input  logic                    ce,
  input  logic                    link_clk,
  input  logic [`P1LC_ADDR_W-1:0] paddr,
  input  logic                    psel,
  input  logic                    penable,
  input  logic                    pwrite,
  input  logic [31:0]             pwdata,
  input  logic [3:0]              pstrb,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  logic [1:0]              port1_operating_mode_strap,
  input  logic                    ref_clock_direction_strap,
  input  logic                    clock_drive_level_strap,
  input  logic                    heartbeat_disable_strap,
  input  logic                    speed_strap,
  input  logic                    turbo_strap,
  input  logic                    duplex_pol_strap,
  input  logic                    port1_duplex_input_pin,
  output logic                    port1_ref_clock_pin_o,
  output logic                    port1_ref_clock_pin_oe,
  output logic                    clock_drive_16ma,
  output p1lc_pkg::p1lc_speed_type link_speed,
  output logic                    link_full_duplex,
  input  logic                    mii_tx_en,
  input  logic [3:0]              mii_txd,
  output logic                    mii_rx_dv,
  output logic [3:0]              mii_rxd,
  output logic                    mii_crs,
  output logic                    mii_col,
  output logic                    mii_out_oe,
  output logic                    link_pull_en,
  input  logic                    sw_tx_en,
  input  logic [3:0]              sw_txd,
  output logic                    sw_rx_dv,
  output logic [3:0]              sw_rxd
);

  function automatic logic [31:0] p1lc_bmask(input logic [3:0] strb);
    p1lc_bmask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
  endfunction : p1lc_bmask

  logic [8:0]                 st1_r;
  logic [8:0]                 st2_r;
  logic [1:0]                 wait_r;
  logic                       loaded_r;
  logic [31:0]                ctrl_r;
  logic [31:0]                ctrl_nxt;
  logic [1:0]                 mode_r;
  logic [31:0]                rd_val;
  logic                       hit;
  logic                       wr_acc;
  logic                       data_ok_r;
  logic [31:0]                prdata_r;
  logic                       pin_full;
  logic                       ckdiv_r;
  logic                       drive_r;
  logic                       full_r;
  p1lc_pkg::p1lc_speed_type   speed_r;
  p1lc_pkg::p1lc_mode_type    mode;
  logic                       phy_mode;
  logic                       mii_phy;
  logic                       turbo;

  p1lc_ctl_if ctl_bus ();

  // Strap pins pass two flops
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st1_r <= 9'h000;
      st2_r <= 9'h000;
    end else if (ce) begin
      st1_r <= {port1_operating_mode_strap, ref_clock_direction_strap,
                clock_drive_level_strap, heartbeat_disable_strap, speed_strap,
                turbo_strap, duplex_pol_strap, port1_duplex_input_pin};
      st2_r <= st1_r;
    end
  end

  // Duplex pin seen through the polarity strap
  assign pin_full = (st2_r[1] == st2_r[0]);

  // Strap load waits for the synchroniser to fill
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wait_r   <= 2'h0;
      loaded_r <= 1'b0;
    end else if (ce && !loaded_r) begin
      if (wait_r == `P1LC_STRAP_WAIT)
        loaded_r <= 1'b1;
      else
        wait_r <= wait_r + 2'h1;
    end
  end

  // APB decode
  assign hit    = (paddr == `P1LC_CTRL_OFS);
  assign wr_acc = psel & penable & pready & pwrite & hit;

  // Register next value
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (!loaded_r && wait_r == `P1LC_STRAP_WAIT) begin
      ctrl_nxt[`P1LC_BIT_CKDIR] = st2_r[6];
      ctrl_nxt[`P1LC_BIT_CKSTR] = st2_r[5];
      ctrl_nxt[`P1LC_BIT_HBDIS] = st2_r[4];
      ctrl_nxt[`P1LC_BIT_SPEED] = st2_r[3];
      ctrl_nxt[`P1LC_BIT_TURBO] = st2_r[2];
      ctrl_nxt[`P1LC_BIT_DUPLEX] = pin_full;
    end else if (wr_acc) begin
      ctrl_nxt = ((ctrl_r & ~p1lc_bmask(pstrb)) | (pwdata & p1lc_bmask(pstrb)))
                 & `P1LC_RW_MASK;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      ctrl_r <= `P1LC_CTRL_RST;
    else if (ce)
      ctrl_r <= ctrl_nxt;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      mode_r <= 2'h0;
    else if (ce && !loaded_r && wait_r == `P1LC_STRAP_WAIT)
      mode_r <= st2_r[8:7];
  end

  assign mode     = p1lc_pkg::p1lc_mode_type'(mode_r);
  assign phy_mode = (mode == p1lc_pkg::P1LC_MII_PHY) || (mode == p1lc_pkg::P1LC_RMII_PHY);
  assign mii_phy  = (mode == p1lc_pkg::P1LC_MII_PHY);
  assign turbo    = ctrl_r[`P1LC_BIT_TURBO];

  always_comb begin
    rd_val = ctrl_r & `P1LC_RD_MASK;
    rd_val[`P1LC_BIT_MODE_HI:`P1LC_BIT_MODE_LO] = mode_r;
  end

  // Read data captured every enabled cycle, zero off the register address
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata_r  <= 32'h0000_0000;
      data_ok_r <= 1'b0;
    end else if (ce) begin
      prdata_r  <= hit ? rd_val : 32'h0000_0000;
      data_ok_r <= psel & ~(penable & pready);
    end
  end

  assign prdata  = prdata_r;
  assign pready  = ce & data_ok_r;
  assign pslverr = psel & penable & pready & ~hit;

  assign port1_ref_clock_pin_oe = ctrl_r[`P1LC_BIT_CKDIR];

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      ckdiv_r <= 1'b0;
    else if (ce)
      ckdiv_r <= ~ckdiv_r;
  end

  assign port1_ref_clock_pin_o = ckdiv_r;

  // Derived link settings
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      drive_r <= 1'b0;
      speed_r <= p1lc_pkg::P1LC_SPD_10;
      full_r  <= 1'b0;
    end else if (ce) begin
      drive_r <= ctrl_r[`P1LC_BIT_CKSTR] &&
                 ((mode == p1lc_pkg::P1LC_RMII_PHY) ||
                  (mii_phy && turbo && ctrl_r[`P1LC_BIT_SPEED]));
      if (!ctrl_r[`P1LC_BIT_SPEED])
        speed_r <= p1lc_pkg::P1LC_SPD_10;
      else if (turbo)
        speed_r <= p1lc_pkg::P1LC_SPD_200;
      else
        speed_r <= p1lc_pkg::P1LC_SPD_100;
      case (mode)
        p1lc_pkg::P1LC_MII_PHY,
        p1lc_pkg::P1LC_RMII_PHY: full_r <= ctrl_r[`P1LC_BIT_DUPLEX];
        p1lc_pkg::P1LC_MII_MAC:  full_r <= ctrl_r[`P1LC_BIT_MANDUP] ?
                                           ctrl_r[`P1LC_BIT_DUPLEX] : pin_full;
        default:                 full_r <= pin_full;
      endcase
    end
  end

  assign clock_drive_16ma = drive_r;
  assign link_speed       = speed_r;
  assign link_full_duplex = full_r;

  // Levels handed to the link domain
  assign ctl_bus.ce       = ce;
  assign ctl_bus.loop_en  = phy_mode & ctrl_r[`P1LC_BIT_LOOP];
  assign ctl_bus.iso_en   = phy_mode & ctrl_r[`P1LC_BIT_ISO];
  assign ctl_bus.colt_en  = mii_phy & ctrl_r[`P1LC_BIT_COLT];
  assign ctl_bus.hb_en    = mii_phy & ~ctrl_r[`P1LC_BIT_HBDIS];
  assign ctl_bus.full_dup = full_r;
  assign ctl_bus.phy_mode = phy_mode;
  assign ctl_bus.mii_phy  = mii_phy;

  p1lc_link u_link (
    .link_clk     (link_clk),
    .rst_b        (rst_b),
    .ctl          (ctl_bus.link),
    .mii_tx_en    (mii_tx_en),
    .mii_txd      (mii_txd),
    .mii_rx_dv    (mii_rx_dv),
    .mii_rxd      (mii_rxd),
    .mii_crs      (mii_crs),
    .mii_col      (mii_col),
    .mii_out_oe   (mii_out_oe),
    .link_pull_en (link_pull_en),
    .sw_tx_en     (sw_tx_en),
    .sw_txd       (sw_txd),
    .sw_rx_dv     (sw_rx_dv),
    .sw_rxd       (sw_rxd)
  );

  a_ref_clk_dir: assert property (
    @(posedge clk) disable iff (!rst_b)
    (ce && wr_acc && loaded_r && pstrb[2]) |=>
      port1_ref_clock_pin_oe == $past(pwdata[`P1LC_BIT_CKDIR]))
    else $error("clock pin direction differs from written bit");

  a_drive_level: assert property (
    @(posedge clk) disable iff (!rst_b)
    (ce && mode == p1lc_pkg::P1LC_MII_PHY && !turbo) |=> !clock_drive_16ma)
    else $error("16 mA drive outside RMII or 200 Mbps");

  a_speed_sel: assert property (
    @(posedge clk) disable iff (!rst_b)
    (ce && !ctrl_r[`P1LC_BIT_SPEED]) |=> (link_speed == p1lc_pkg::P1LC_SPD_10))
    else $error("speed not 10 Mbps with select low");

  a_turbo_rate: assert property (
    @(posedge clk) disable iff (!rst_b)
    (ce && ctrl_r[`P1LC_BIT_SPEED] && turbo) |=> (link_speed == p1lc_pkg::P1LC_SPD_200))
    else $error("turbo high rate not 200 Mbps");

  a_strap_load: assert property (
    @(posedge clk) disable iff (!rst_b)
    (ce && !loaded_r && wait_r == `P1LC_STRAP_WAIT) |=>
      (ctrl_r[`P1LC_BIT_CKDIR] == $past(st2_r[6]) &&
       ctrl_r[`P1LC_BIT_SPEED] == $past(st2_r[3]) &&
       ctrl_r[`P1LC_BIT_HBDIS] == $past(st2_r[4])))
    else $error("strap default not loaded");

  a_dup_strap: assert property (
    @(posedge clk) disable iff (!rst_b)
    (ce && !loaded_r && wait_r == `P1LC_STRAP_WAIT) |=>
      ctrl_r[`P1LC_BIT_DUPLEX] == ($past(st2_r[1]) == $past(st2_r[0])))
    else $error("duplex default does not match strap and pin");

  a_mode_read: assert property (
    @(posedge clk) disable iff (!rst_b)
    (ce && psel && !penable && hit) |=> prdata[25:24] == $past(mode_r))
    else $error("mode field read back wrong");

  a_mac_duplex: assert property (
    @(posedge clk) disable iff (!rst_b)
    (ce && mode == p1lc_pkg::P1LC_MII_MAC && !ctrl_r[`P1LC_BIT_MANDUP]) |=>
      link_full_duplex == $past(pin_full))
    else $error("MAC duplex ignores the pin");

  a_rsvd_zero: assert property (
    @(posedge clk) disable iff (!rst_b)
    (prdata & ~`P1LC_RD_MASK) == 32'h0000_0000)
    else $error("reserved bits read nonzero");

  a_phy_duplex: assert property (
    @(posedge clk) disable iff (!rst_b)
    (ce && phy_mode) |=> link_full_duplex == $past(ctrl_r[`P1LC_BIT_DUPLEX]))
    else $error("PHY duplex differs from duplex bit");

  a_write_lands: assert property (
    @(posedge clk) disable iff (!rst_b)
    (ce && wr_acc && loaded_r) |=>
      (((ctrl_r ^ $past(pwdata)) & `P1LC_RW_MASK & p1lc_bmask($past(pstrb))) == 32'h0000_0000 &&
       (ctrl_r & ~`P1LC_RW_MASK) == 32'h0000_0000))
    else $error("write did not land on writable bits only");

endmodule : p1lc_top

// File: tb/p1lc_mac_model.sv
// Behavioural external MAC driving the transmit side of the port 1 link
`timescale 1ns/1ps
module p1lc_mac_model (
  input  wire logic       link_clk,
  output logic            tx_en,
  output logic [3:0]      txd
);
  initial begin
    tx_en = 1'b0;
    txd   = 4'h0;
  end

  task send_nib(input logic [3:0] d);
    @(posedge link_clk);
    tx_en <= 1'b1;
    txd   <= d;
  endtask : send_nib

  // Idle data lines change every cycle so stale nibbles never match
  task idle(input int n);
    repeat (n) begin
      @(posedge link_clk);
      tx_en <= 1'b0;
      txd   <= ~txd;
    end
  endtask : idle
endmodule : p1lc_mac_model

// File: tb/port1_mii_phy_mode_control_bench.sv
// Self-checking bench for the port 1 link control block
`timescale 1ns/1ps
`include "p1lc_consts.svh"
`define CHK(g, e) begin \
  n_tests++; \
  if ((g) !== (e)) begin \
    num_errors++; \
    $display("unexpected at %0t: got %0h, expected %0h", $time, g, e); \
  end \
end
module port1_mii_phy_mode_control_bench;
  localparam logic [31:0] ofs    = 32'h0000_01EC;
  localparam logic [31:0] base   = 32'h0461_2100;
  localparam logic [31:0] b_loop = 32'h0000_4000;
  localparam logic [31:0] b_colt = 32'h0000_0080;
  localparam logic [31:0] b_iso  = 32'h0000_0400;
  localparam logic [31:0] b_hb   = 32'h0001_0000;
  logic                     clk, link_clk, rst_b, ce, psel, penable, pwrite;
  logic [11:0]              paddr;
  logic [31:0]              pwdata, prdata, seed;
  logic                     pready, pslverr, ref_oe, ref_o, drv16, full_dup;
  logic [1:0]               mode_s;
  logic                     ckdir_s, ckstr_s, hbdis_s, spd_s, turbo_s, pol_s, pin_s;
  p1lc_pkg::p1lc_speed_type link_speed, spd_exp;
  logic                     mii_tx_en, mii_rx_dv, mii_crs, mii_col, mii_out_oe, link_pull_en;
  logic                     sw_tx_en, sw_rx_dv;
  logic [3:0]               mii_txd, mii_rxd, sw_txd, sw_rxd, nib, rx_exp, sw_exp;
  logic [32:0]              apb_exp;
  logic [32:0]              apbq[$];
  logic [3:0]               rxq[$], swq[$];
  int                       num_errors, n_tests, cnt;

  p1lc_top uut (.clk(clk), .rst_b(rst_b), .ce(ce), .link_clk(link_clk), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hF),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .port1_operating_mode_strap(mode_s), .ref_clock_direction_strap(ckdir_s),
    .clock_drive_level_strap(ckstr_s), .heartbeat_disable_strap(hbdis_s),
    .speed_strap(spd_s), .turbo_strap(turbo_s), .duplex_pol_strap(pol_s),
    .port1_duplex_input_pin(pin_s), .port1_ref_clock_pin_o(ref_o),
    .port1_ref_clock_pin_oe(ref_oe), .clock_drive_16ma(drv16), .link_speed(link_speed),
    .link_full_duplex(full_dup), .mii_tx_en(mii_tx_en), .mii_txd(mii_txd),
    .mii_rx_dv(mii_rx_dv), .mii_rxd(mii_rxd), .mii_crs(mii_crs), .mii_col(mii_col),
    .mii_out_oe(mii_out_oe), .link_pull_en(link_pull_en), .sw_tx_en(sw_tx_en),
    .sw_txd(sw_txd), .sw_rx_dv(sw_rx_dv), .sw_rxd(sw_rxd));
  p1lc_mac_model mac (.link_clk(link_clk), .tx_en(mii_tx_en), .txd(mii_txd));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever #62.5 link_clk = ~link_clk;
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  function automatic logic [31:0] exp_rst();
    return {5'h00, turbo_s, mode_s, 1'b0, ckdir_s, ckstr_s, 4'h0, hbdis_s, 2'h0, spd_s,
            4'h0, pol_s == pin_s, 8'h00};
  endfunction : exp_rst

  task finish_test();
    if (num_errors == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : finish_test

  // Straps held stable from release until well after the load
  task do_reset(input logic [1:0] m, input logic fix);
    logic [31:0] r;
    r = fix ? 32'hFFFF_FFFF : xs();
    rst_b <= 1'b0;
    mode_s <= m;
    {ckdir_s, ckstr_s, hbdis_s, spd_s, turbo_s, pol_s, pin_s} <= r[6:0];
    repeat (3) @(posedge clk);
    repeat (2) @(posedge link_clk);
    @(posedge clk);
    rst_b <= 1'b1;
    repeat (6) @(posedge clk);
  endtask : do_reset

  task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task rd(input logic [31:0] a, input logic [32:0] e);
    apbq.push_back(e);
    apb(a[11:0], 1'b0, 32'h0000_0000);
  endtask : rd

  task wr(input logic [31:0] a, input logic [31:0] d);
    apb(a[11:0], 1'b1, d);
    repeat (6) @(posedge link_clk);
  endtask : wr

  task tx(input int n, input int dest);
    repeat (n) begin
      nib = xs();
      if (dest == 1)
        rxq.push_back(nib);
      if (dest == 2)
        swq.push_back(nib);
      mac.send_nib(nib);
    end
  endtask : tx

  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      apb_exp = apbq.pop_front();
      `CHK({pslverr, prdata}, apb_exp)
    end
  end

  always @(posedge link_clk) begin
    if (mii_rx_dv === 1'b1) begin
      rx_exp = rxq.pop_front();
      `CHK(mii_rxd, rx_exp)
    end
    if (sw_rx_dv === 1'b1) begin
      sw_exp = swq.pop_front();
      `CHK(sw_rxd, sw_exp)
    end
  end

  initial begin
    repeat (60000) @(posedge clk);
    num_errors++;
    finish_test();
  end

  initial begin
    num_errors = 0;
    n_tests = 0;
    seed = 32'h0001_182F;
    ce = 1'b1;
    rst_b = 1'b0;
    {psel, penable, pwrite, sw_tx_en} = 4'h0;
    {paddr, pwdata, sw_txd} = 48'h0;
    {mode_s, ckdir_s, ckstr_s, hbdis_s, spd_s, turbo_s, pol_s, pin_s} = 9'h000;
    do_reset(2'h1, 1'b1);
    rd(ofs, {1'b0, exp_rst()});
    `CHK(link_speed, p1lc_pkg::P1LC_SPD_200)
    nib[0] = ref_o;
    @(posedge clk);
    `CHK(ref_o, ~nib[0])
    wr(ofs, 32'hFFFF_FFFF);
    rd(ofs, {1'b0, `P1LC_RW_MASK | 32'h0100_0000});
    wr(32'h0000_01F0, 32'h0000_0000);
    rd(32'h0000_01F0, {1'b1, 32'h0000_0000});
    rd(ofs, {1'b0, `P1LC_RW_MASK | 32'h0100_0000});
    for (int i = 0; i < 4; i++) begin
      wr(ofs, 32'h0060_0100 | (i[1] ? 32'h0400_0000 : 32'h0) | (i[0] ? 32'h0000_2000 : 32'h0));
      spd_exp = !i[0] ? p1lc_pkg::P1LC_SPD_10 :
                i[1]  ? p1lc_pkg::P1LC_SPD_200 : p1lc_pkg::P1LC_SPD_100;
      `CHK(link_speed, spd_exp)
      `CHK(drv16, i[1] & i[0])
    end
    `CHK(full_dup, 1'b1)
    wr(ofs, base & 32'hFFFF_FEFF);
    `CHK(full_dup, 1'b0)
    tx(4, 2);
    mac.idle(2);
    repeat (4) begin
      nib = xs();
      rxq.push_back(nib);
      @(posedge link_clk);
      sw_tx_en <= 1'b1;
      sw_txd <= nib;
    end
    @(posedge link_clk);
    sw_tx_en <= 1'b0;
    wr(ofs, base | b_loop | b_colt);
    tx(3, 1);
    `CHK(mii_col, 1'b1)
    `CHK(mii_crs, 1'b1)
    mac.idle(3);
    `CHK(mii_col, 1'b0)
    `CHK(mii_crs, 1'b0)
    wr(ofs, (base & ~b_hb) | b_loop);
    tx(2, 1);
    cnt = 0;
    repeat (10) begin
      mac.idle(1);
      if (mii_col === 1'b1)
        cnt++;
    end
    `CHK(cnt, 4)
    wr(ofs, base | b_iso);
    `CHK(mii_out_oe, 1'b0)
    `CHK(link_pull_en, 1'b0)
    tx(3, 0);
    mac.idle(4);
    for (int m = 0; m < 4; m++) begin
      do_reset(m[1:0], 1'b0);
      rd(ofs, {1'b0, exp_rst()});
      `CHK(ref_oe, ckdir_s)
      if (m == 1 || m == 2)
        `CHK(full_dup, pol_s == pin_s)
    end
    do_reset(2'h0, 1'b0);
    pin_s <= ~pol_s;
    repeat (6) @(posedge clk);
    `CHK(full_dup, 1'b0)
    // Pin change must not pass while the clock enable is low
    ce    <= 1'b0;
    pin_s <= pol_s;
    repeat (6) @(posedge clk);
    `CHK(full_dup, 1'b0)
    ce    <= 1'b1;
    repeat (6) @(posedge clk);
    `CHK(full_dup, 1'b1)
    wr(ofs, 32'h1000_0000);
    `CHK(full_dup, 1'b0)
    `CHK(apbq.size() + rxq.size() + swq.size(), 0)
    finish_test();
  end
endmodule : port1_mii_phy_mode_control_bench
